// File: design/mmt_pkg.sv
/*
 * Shared constants, register map and carrier types of the multimode timer block.
 * Assumes a 32-bit AXI4-Lite register bus and a single 250 MHz system clock.
 */
package mmt_pkg;
	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam int         ADDR_W       = 8;
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_A_MODE   = 8'h04;
	localparam logic [7:0] OFS_A_COUNT  = 8'h08;
	localparam logic [7:0] OFS_A_DUTY   = 8'h0C;
	localparam logic [7:0] OFS_B_MODE   = 8'h10;
	localparam logic [7:0] OFS_B_COUNT  = 8'h14;
	localparam logic [7:0] OFS_RTP_DATA = 8'h18;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
	localparam logic [7:0] OFS_IRQ_CLR  = 8'h20;
	localparam logic [7:0] OFS_IRQ_EN   = 8'h24;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int CTRL_A_START = 0;
	localparam int CTRL_B_START = 1;
	localparam int CTRL_RTP_EN  = 2;
	localparam int CTRL_A_TRIG  = 3;
	localparam int IRQ_A        = 0;
	localparam int IRQ_B        = 1;
	localparam int IRQ_W        = 2;
	localparam int RTP_W        = 8;

	// ---------------------------------------------------------------
	// Values and reset values
	// ---------------------------------------------------------------
	localparam logic [15:0] CNT_ONES    = 16'hFFFF;
	localparam logic [15:0] CNT_ZEROS   = 16'h0000;
	localparam logic [15:0] CNT_ONE     = 16'h0001;
	localparam logic [15:0] RST_RELOAD  = 16'hFFFF;
	localparam logic [15:0] RST_DUTY    = 16'h0000;
	localparam logic [1:0]  RESP_OKAY   = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;

	// ---------------------------------------------------------------
	// Modes and configuration carriers
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		MMT_A_TIMER   = 2'b00,
		MMT_A_EVENT   = 2'b01,
		MMT_A_ONESHOT = 2'b10,
		MMT_A_PWM     = 2'b11
	} mmt_amode_t;

	typedef enum logic [1:0] {
		MMT_B_TIMER   = 2'b00,
		MMT_B_EVENT   = 2'b01,
		MMT_B_MEASURE = 2'b10
	} mmt_bmode_t;

	typedef struct packed {
		logic       gate_en;
		logic       free_run;
		logic       count_up;
		mmt_amode_t mode;
	} mmt_acfg_t;

	typedef struct packed {
		logic       width_sel;
		mmt_bmode_t mode;
	} mmt_bcfg_t;

	localparam mmt_acfg_t RST_ACFG = '{gate_en: 1'b0, free_run: 1'b0, count_up: 1'b0,
		mode: MMT_A_TIMER};
	localparam mmt_bcfg_t RST_BCFG = '{width_sel: 1'b0, mode: MMT_B_TIMER};
endpackage

// File: design/mmt_timer_b.sv
/*
 * Input timer: timer, event counter and pulse period / pulse width measurement.
 * Assumes tick is a one-cycle enable from the prescaler and edge_in is synchronous.
 */
`timescale 1ns/1ps
module mmt_timer_b (
	input  wire logic              sys_clk,
	input  wire logic              sys_rst,
	input  wire logic              tick,
	input  wire logic              edge_in,
	input  wire logic              start,
	input  wire mmt_pkg::mmt_bcfg_t cfg,
	input  wire logic              cnt_wr,
	input  wire logic [15:0]       cnt_wdata,
	output logic      [15:0]       rd_value,
	output logic                   irq_set
);
	import mmt_pkg::*;

	logic [15:0] cnt_q, cnt_d;
	logic [15:0] reload_q, reload_d;
	logic        prev_q, prev_d;
	logic        first_q, first_d;
	logic        wsel_q, wsel_d;
	logic        reload_now;

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		logic rise;
		logic fall;
		logic eff;
		rise       = edge_in & ~prev_q;
		fall       = ~edge_in & prev_q;
		eff        = cfg.width_sel ? (rise | fall) : rise;
		cnt_d      = cnt_q;
		reload_d   = reload_q;
		prev_d     = edge_in;
		first_d    = first_q;
		wsel_d     = cfg.width_sel;
		irq_set    = 1'b0;
		reload_now = 1'b0;
		if (!start) begin
			first_d = 1'b1;
		end
		unique case (cfg.mode)
			MMT_B_TIMER, MMT_B_EVENT: begin
				if (start && ((cfg.mode == MMT_B_TIMER) ? tick : rise)) begin
					if (cnt_q == CNT_ZEROS) begin
						reload_now = 1'b1;
						cnt_d      = reload_q;
						irq_set    = 1'b1;
					end else begin
						cnt_d = cnt_q - CNT_ONE;
					end
				end
			end
			MMT_B_MEASURE: begin
				if (start && (wsel_q != cfg.width_sel)) begin
					irq_set = 1'b1;
				end
				if (start && eff) begin
					reload_d = cnt_q;
					cnt_d    = CNT_ZEROS;
					first_d  = 1'b0;
					if (!first_q) begin
						irq_set = 1'b1;
					end
				end else if (start && tick) begin
					cnt_d = cnt_q + CNT_ONE;
				end
			end
			default: begin
				cnt_d = cnt_q;
			end
		endcase
		if (cnt_wr) begin
			reload_d = cnt_wdata;
			if (!start) begin
				cnt_d = cnt_wdata;
			end
		end
	end

	assign rd_value = (cfg.mode == MMT_B_MEASURE) ? reload_q :
		(reload_now ? CNT_ONES : cnt_q);

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cnt_q    <= CNT_ZEROS;
			reload_q <= RST_RELOAD;
			prev_q   <= 1'b0;
			first_q  <= 1'b1;
			wsel_q   <= 1'b0;
		end else begin
			cnt_q    <= cnt_d;
			reload_q <= reload_d;
			prev_q   <= prev_d;
			first_q  <= first_d;
			wsel_q   <= wsel_d;
		end
	end
endmodule

// File: design/mmt_top.sv
/*
 * Multimode timer block: one output timer, one input timer, real-time port latch,
 * interrupt status/enable/clear and an AXI4-Lite register slave.
 * Assumes a single sys_clk domain and event inputs already synchronous to it.
 */
`timescale 1ns/1ps

module mmt_top #(
	parameter int PRESCALE = 4
) (
	input  wire logic                       sys_clk,
	input  wire logic                       sys_rst,
	input  wire logic [mmt_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [mmt_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic                       a_event_in,
	input  wire logic                       b_event_in,
	output logic                            output_timer_pin,
	output logic [mmt_pkg::RTP_W-1:0]       rtp_port,
	output logic                            irq
);
	import mmt_pkg::*;

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		is_mapped = (a <= OFS_IRQ_EN) && (a[1:0] == 2'b00);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		merge = (old & ~m) | (d & m);
	endfunction

	// ---------------------------------------------------------------
	// Prescaler
	// ---------------------------------------------------------------
	localparam int DIV_W = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
	logic [DIV_W-1:0] div_q, div_d;
	logic             tick;

	always_comb begin
		tick  = (div_q == DIV_W'(PRESCALE - 1));
		div_d = tick ? '0 : div_q + DIV_W'(1);
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite slave
	// ---------------------------------------------------------------
	logic              aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic [ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [31:0]       wdata_q, wdata_d;
	logic [3:0]        wstrb_q, wstrb_d;
	logic              bvalid_q, bvalid_d, rvalid_q, rvalid_d, arready_q, arready_d;
	logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0]       rdata_q, rdata_d;
	logic              wr_go;
	logic [31:0]       rd_word;

	always_comb begin
		aw_have_d = aw_have_q;
		w_have_d  = w_have_q;
		awaddr_d  = awaddr_q;
		wdata_d   = wdata_q;
		wstrb_d   = wstrb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q;
		rresp_d   = rresp_q;
		rdata_d   = rdata_q;
		arready_d = arready_q;
		wr_go     = aw_have_q && w_have_q && !bvalid_q;
		if (s_axi_bvalid && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (wr_go) begin
			aw_have_d = 1'b0;
			w_have_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = is_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
		end
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_d = 1'b1;
			awaddr_d  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_d = 1'b1;
			wdata_d  = s_axi_wdata;
			wstrb_d  = s_axi_wstrb;
		end
		if (s_axi_rvalid && s_axi_rready) begin
			rvalid_d  = 1'b0;
			arready_d = 1'b1;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			arready_d = 1'b0;
			rvalid_d  = 1'b1;
			rdata_d   = is_mapped(s_axi_araddr) ? rd_word : 32'h0000_0000;
			rresp_d   = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awaddr_q  <= '0;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			rvalid_q  <= 1'b0;
			rresp_q   <= RESP_OKAY;
			rdata_q   <= 32'h0000_0000;
			arready_q <= 1'b0;
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q  <= w_have_d;
			awaddr_q  <= awaddr_d;
			wdata_q   <= wdata_d;
			wstrb_q   <= wstrb_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			rvalid_q  <= rvalid_d;
			rresp_q   <= rresp_d;
			rdata_q   <= rdata_d;
			arready_q <= arready_d | ~rvalid_d;
		end
	end

	// A held address or data beat blocks its own channel until the write is done
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= ~aw_have_d & ~(s_axi_awvalid & s_axi_awready);
			s_axi_wready  <= ~w_have_d & ~(s_axi_wvalid & s_axi_wready);
		end
	end

	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_arready = arready_q;

	// ---------------------------------------------------------------
	// Output timer, control, port latch and interrupts
	// ---------------------------------------------------------------
	mmt_acfg_t          acfg_q, acfg_d;
	mmt_bcfg_t          bcfg_q, bcfg_d;
	logic [15:0]        acnt_q, acnt_d, arel_q, arel_d, aduty_q, aduty_d;
	logic               astart_q, astart_d, bstart_q, bstart_d, rtpen_q, rtpen_d;
	logic               apin_q, apin_d, aact_q, aact_d, aprev_q, aprev_d;
	logic [RTP_W-1:0]   rtpd_q, rtpd_d, rtp_q, rtp_d;
	logic [IRQ_W-1:0]   stat_q, stat_d, en_q, en_d;
	logic               irq_q, irq_d;
	logic               a_reload_now, b_irq_set, b_cnt_wr;
	logic [15:0]        a_rd, b_rd;
	logic [31:0]        wval;

	always_comb begin
		logic [IRQ_W-1:0] set;
		logic [IRQ_W-1:0] clr;
		logic             step;
		logic             at_lim;
		logic             a_stop;
		set        = '0;
		clr        = '0;
		a_stop     = 1'b0;
		acfg_d     = acfg_q;
		bcfg_d     = bcfg_q;
		acnt_d     = acnt_q;
		arel_d     = arel_q;
		aduty_d    = aduty_q;
		astart_d   = astart_q;
		bstart_d   = bstart_q;
		rtpen_d    = rtpen_q;
		apin_d     = apin_q;
		aact_d     = aact_q;
		aprev_d    = a_event_in;
		rtpd_d     = rtpd_q;
		rtp_d      = rtp_q;
		en_d       = en_q;
		b_cnt_wr   = 1'b0;
		wval       = 32'h0000_0000;
		step       = 1'b0;
		at_lim     = 1'b0;
		a_reload_now = 1'b0;
		unique case (acfg_q.mode)
			MMT_A_TIMER:   step = tick;
			MMT_A_EVENT:   step = a_event_in & ~aprev_q;
			MMT_A_ONESHOT: step = tick & aact_q;
			MMT_A_PWM:     step = tick;
		endcase
		if (acfg_q.mode == MMT_A_EVENT && acfg_q.count_up) begin
			at_lim = (acnt_q == CNT_ONES);
		end else begin
			at_lim = (acnt_q == CNT_ZEROS);
		end
		// Counting uses the state before any write of this cycle
		if (astart_q && step) begin
			unique case (acfg_q.mode)
				MMT_A_TIMER, MMT_A_EVENT: begin
					if (at_lim) begin
						a_reload_now = 1'b1;
						set[IRQ_A]   = 1'b1;
						acnt_d = acfg_q.free_run ? ~acnt_q : arel_q;
						if (rtpen_q && acfg_q.mode == MMT_A_TIMER) begin
							rtp_d = rtpd_q;
						end
					end else begin
						acnt_d = acfg_q.count_up && acfg_q.mode == MMT_A_EVENT ?
							acnt_q + CNT_ONE : acnt_q - CNT_ONE;
					end
				end
				MMT_A_ONESHOT: begin
					if (at_lim) begin
						aact_d     = 1'b0;
						apin_d     = 1'b0;
						acnt_d     = arel_q;
						set[IRQ_A] = 1'b1;
					end else begin
						acnt_d = acnt_q - CNT_ONE;
					end
				end
				MMT_A_PWM: begin
					acnt_d = at_lim ? arel_q : acnt_q - CNT_ONE;
					apin_d = (acnt_d < aduty_q);
					if (apin_q && !apin_d) begin
						set[IRQ_A] = 1'b1;
					end
				end
			endcase
		end
		if (wr_go && is_mapped(awaddr_q)) begin
			wval = merge(rd_word_at(awaddr_q), wdata_q, wstrb_q);
			unique case (awaddr_q)
				OFS_CTRL: begin
					astart_d = wval[CTRL_A_START];
					bstart_d = wval[CTRL_B_START];
					rtpen_d  = wval[CTRL_RTP_EN];
					if (wval[CTRL_A_TRIG] && wval[CTRL_A_START] &&
						acfg_q.mode == MMT_A_ONESHOT) begin
						aact_d = 1'b1;
						apin_d = 1'b1;
						acnt_d = arel_q;
					end
				end
				OFS_A_MODE: begin
					acfg_d = mmt_acfg_t'(wval[4:0]);
					if ((acfg_d.mode == MMT_A_ONESHOT || acfg_d.mode == MMT_A_PWM) &&
						(acfg_q.mode == MMT_A_TIMER || acfg_q.mode == MMT_A_EVENT)) begin
						set[IRQ_A] = 1'b1;
					end
				end
				OFS_A_COUNT: begin
					arel_d = wval[15:0];
					if (!astart_q) begin
						acnt_d = wval[15:0];
					end
				end
				OFS_A_DUTY:   aduty_d  = wval[15:0];
				OFS_B_MODE:   bcfg_d   = mmt_bcfg_t'(wval[2:0]);
				OFS_B_COUNT:  b_cnt_wr = 1'b1;
				OFS_RTP_DATA: rtpd_d   = wval[RTP_W-1:0];
				OFS_IRQ_CLR:  clr      = wval[IRQ_W-1:0];
				OFS_IRQ_EN:   en_d     = wval[IRQ_W-1:0];
				default: begin
					clr = '0;
				end
			endcase
		end
		a_stop = astart_q && !astart_d;
		if (a_stop && acfg_q.mode == MMT_A_ONESHOT && aact_q) begin
			aact_d     = 1'b0;
			acnt_d     = arel_q;
			apin_d     = 1'b0;
			set[IRQ_A] = 1'b1;
		end
		if (a_stop && acfg_q.mode == MMT_A_PWM) begin
			// request only if pin was high
			apin_d     = 1'b0;
			set[IRQ_A] = apin_q;
			acnt_d     = acnt_q;
		end
		set[IRQ_B] = b_irq_set;
		// Set wins over a clear in the same cycle
		stat_d = (stat_q & ~clr) | set;
		irq_d  = |(stat_d & en_d);
	end

	// live count, fixed value at reload
	assign a_rd = !a_reload_now ? acnt_q :
		((acfg_q.mode == MMT_A_EVENT && acfg_q.count_up) ? CNT_ZEROS : CNT_ONES);

	function automatic logic [31:0] rd_word_at(input logic [ADDR_W-1:0] a);
		unique case (a)
			OFS_CTRL:     rd_word_at = {29'h0, rtpen_q, bstart_q, astart_q};
			OFS_A_MODE:   rd_word_at = {27'h0, acfg_q};
			OFS_A_COUNT:  rd_word_at = {16'h0, a_rd};
			OFS_A_DUTY:   rd_word_at = {16'h0, aduty_q};
			OFS_B_MODE:   rd_word_at = {29'h0, bcfg_q};
			OFS_B_COUNT:  rd_word_at = {16'h0, b_rd};
			OFS_RTP_DATA: rd_word_at = {24'h0, rtpd_q};
			OFS_IRQ_STAT: rd_word_at = {30'h0, stat_q};
			OFS_IRQ_EN:   rd_word_at = {30'h0, en_q};
			default:      rd_word_at = 32'h0000_0000;
		endcase
	endfunction

	assign rd_word = rd_word_at(s_axi_araddr);

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			acfg_q   <= RST_ACFG;
			bcfg_q   <= RST_BCFG;
			acnt_q   <= CNT_ZEROS;
			arel_q   <= RST_RELOAD;
			aduty_q  <= RST_DUTY;
			astart_q <= 1'b0;
			bstart_q <= 1'b0;
			rtpen_q  <= 1'b0;
			apin_q   <= 1'b0;
			aact_q   <= 1'b0;
			aprev_q  <= 1'b0;
			rtpd_q   <= '0;
			rtp_q    <= '0;
			stat_q   <= '0;
			en_q     <= '0;
			irq_q    <= 1'b0;
		end else begin
			acfg_q   <= acfg_d;
			bcfg_q   <= bcfg_d;
			acnt_q   <= acnt_d;
			arel_q   <= arel_d;
			aduty_q  <= aduty_d;
			astart_q <= astart_d;
			bstart_q <= bstart_d;
			rtpen_q  <= rtpen_d;
			apin_q   <= apin_d;
			aact_q   <= aact_d;
			aprev_q  <= aprev_d;
			rtpd_q   <= rtpd_d;
			rtp_q    <= rtp_d;
			stat_q   <= stat_d;
			en_q     <= en_d;
			irq_q    <= irq_d;
		end
	end

	assign output_timer_pin = apin_q;
	assign rtp_port         = rtp_q;
	assign irq              = irq_q;

	// ---------------------------------------------------------------
	// Input timer
	// ---------------------------------------------------------------
	mmt_timer_b u_timer_b (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.tick      (tick),
		.edge_in   (b_event_in),
		.start     (bstart_q),
		.cfg       (bcfg_q),
		.cnt_wr    (b_cnt_wr),
		.cnt_wdata (wval[15:0]),
		.rd_value  (b_rd),
		.irq_set   (b_irq_set)
	);
endmodule

// File: sim/mmt_top_properties.sv
/*
 * Port-level checks of the multimode timer block: register bus handshakes and reset.
 * Assumes it is bound to mmt_top, one sys_clk domain, active-high sys_rst.
 */
`timescale 1ns/1ps
module mmt_top_properties (
	input wire logic                       sys_clk,
	input wire logic                       sys_rst,
	input wire logic                       s_axi_awvalid,
	input wire logic                       s_axi_awready,
	input wire logic                       s_axi_wvalid,
	input wire logic                       s_axi_wready,
	input wire logic [1:0]                 s_axi_bresp,
	input wire logic                       s_axi_bvalid,
	input wire logic                       s_axi_bready,
	input wire logic [mmt_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic                       s_axi_arvalid,
	input wire logic                       s_axi_arready,
	input wire logic [31:0]                s_axi_rdata,
	input wire logic [1:0]                 s_axi_rresp,
	input wire logic                       s_axi_rvalid,
	input wire logic                       s_axi_rready,
	input wire logic                       output_timer_pin,
	input wire logic                       irq
);
	import mmt_pkg::*;
	logic rd_bad;
	logic ar_take;
	// Unmapped: past the last register or not word aligned
	assign rd_bad  = (s_axi_araddr > OFS_IRQ_EN) || (s_axi_araddr[1:0] != 2'b00);
	assign ar_take = s_axi_arvalid && s_axi_arready;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data moved");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while data pending");
	a_read_answer: assert property (ar_take |=> s_axi_rvalid)
		else $error("read answer late");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
	a_aw_single: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("second write address accepted");
	a_rd_slverr: assert property (ar_take && rd_bad |=>
		s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read answered");
	a_rd_okay: assert property (ar_take && !rd_bad |=> s_axi_rresp == RESP_OKAY)
		else $error("mapped read refused");
	a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> !s_axi_bvalid
		&& !s_axi_rvalid && !irq && !output_timer_pin && !s_axi_awready)
		else $error("outputs active in reset");

	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
	c_pin_fall: cover property ($fell(output_timer_pin));
	c_irq_rise: cover property ($rose(irq));
endmodule

bind mmt_top mmt_top_properties u_props (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .output_timer_pin(output_timer_pin), .irq(irq)
);

// File: sim/mmt_top_tb.sv
/*
 * Self-checking bench of mmt_top through its AXI4-Lite registers.
 * Assumes PRESCALE 1, so the timers advance every clock.
 */
`timescale 1ns/1ps
module mmt_top_tb;
	import mmt_pkg::*;
	logic              sys_clk, sys_rst, a_event_in, b_event_in, output_timer_pin, irq;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0]       s_axi_wdata, s_axi_rdata, rdat;
	logic [3:0]        s_axi_wstrb;
	logic [1:0]        s_axi_bresp, s_axi_rresp, rsp;
	logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic              s_axi_rvalid, s_axi_rready;
	logic [RTP_W-1:0]  rtp_port;
	int                errors, tests_run, n;

	mmt_top #(.PRESCALE(1)) u_dut (.sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.a_event_in, .b_event_in, .output_timer_pin, .rtp_port, .irq);

	always #2 sys_clk = ~sys_clk;

	// ---------------------------------------------------------------
	// Bus and compare tasks
	// ---------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	// Entering on a fresh edge keeps a strobe from being assigned twice in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (k = 0; k < 64; k++) begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		rsp = s_axi_bresp;
		if (k == 64) errors++;
	endtask

	task automatic rd(input logic [7:0] a);
		int k;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (k = 0; k < 64; k++) begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		rdat = s_axi_rdata;
		rsp = s_axi_rresp;
		if (k == 64) errors++;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string name);
		rd(a);
		check(name, exp, rdat);
	endtask

	task automatic settle;
		repeat (3) @(posedge sys_clk);
	endtask

	task automatic conclude;
		if (errors == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// A hang ends the run after far more than the sequence needs
	initial begin
		#80000;
		errors++;
		conclude();
	end

	// ---------------------------------------------------------------
	// Test sequence
	// ---------------------------------------------------------------
	initial begin
		{sys_clk, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, a_event_in, b_event_in, s_axi_awaddr, s_axi_araddr} = '0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		sys_rst = 1'b1;
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rdchk(OFS_A_MODE, 32'h0, "a_mode_reset");
		rdchk(OFS_A_COUNT, 32'h0, "a_count_reset");
		rdchk(OFS_IRQ_STAT, 32'h0, "irq_stat_reset");
		check("rtp_reset", 32'h0, {24'h0, rtp_port});
		rdchk(8'h28, 32'h0, "unmapped_rdata");
		check("unmapped_rresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
		wr(8'h32, 32'h1);
		check("unmapped_bresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
		wr(OFS_A_COUNT, 32'h1234);
		rdchk(OFS_A_COUNT, 32'h1234, "a_count_halted");
		// Event counter counts down on rising inputs
		wr(OFS_A_MODE, 32'h1);
		wr(OFS_A_COUNT, 32'h10);
		wr(OFS_CTRL, 32'h1);
		repeat (3) begin
			@(posedge sys_clk) a_event_in <= 1'b1;
			@(posedge sys_clk) a_event_in <= 1'b0;
		end
		rdchk(OFS_A_COUNT, 32'hD, "a_count_live");
		wr(OFS_CTRL, 32'h0);
		wr(OFS_A_COUNT, 32'h100);
		wr(OFS_IRQ_CLR, 32'h3);
		wr(OFS_A_MODE, 32'h3);
		rdchk(OFS_IRQ_STAT, 32'h1, "stat_pwm_select");
		// Full-duty pulse: stop while high
		wr(OFS_IRQ_CLR, 32'h3);
		wr(OFS_A_DUTY, 32'hFFFF);
		wr(OFS_CTRL, 32'h1);
		settle();
		check("pwm_pin_high", 32'h1, {31'h0, output_timer_pin});
		wr(OFS_CTRL, 32'h0);
		settle();
		check("pwm_pin_stop", 32'h0, {31'h0, output_timer_pin});
		rdchk(OFS_IRQ_STAT, 32'h1, "stat_pwm_stop_high");
		// Zero duty: stop while low
		wr(OFS_IRQ_CLR, 32'h3);
		wr(OFS_A_DUTY, 32'h0);
		wr(OFS_CTRL, 32'h1);
		settle();
		check("pwm_pin_low", 32'h0, {31'h0, output_timer_pin});
		wr(OFS_CTRL, 32'h0);
		rdchk(OFS_IRQ_STAT, 32'h0, "stat_pwm_stop_low");
		// One-shot chosen from timer mode, then aborted
		wr(OFS_A_MODE, 32'h0);
		wr(OFS_IRQ_CLR, 32'h3);
		wr(OFS_A_MODE, 32'h2);
		rdchk(OFS_IRQ_STAT, 32'h1, "stat_oneshot_select");
		wr(OFS_IRQ_CLR, 32'h3);
		wr(OFS_CTRL, 32'h9);
		settle();
		check("oneshot_pin_run", 32'h1, {31'h0, output_timer_pin});
		wr(OFS_CTRL, 32'h0);
		settle();
		check("oneshot_pin_abort", 32'h0, {31'h0, output_timer_pin});
		rdchk(OFS_IRQ_STAT, 32'h1, "stat_oneshot_abort");
		rdchk(OFS_A_COUNT, 32'h100, "oneshot_reload");
		// Port latch follows timer underflow
		wr(OFS_A_MODE, 32'h0);
		wr(OFS_A_COUNT, 32'h3);
		wr(OFS_RTP_DATA, 32'hA5);
		wr(OFS_CTRL, 32'h5);
		for (n = 0; n < 100 && rtp_port !== 8'hA5; n++) @(posedge sys_clk);
		check("rtp_port", 32'hA5, {24'h0, rtp_port});
		wr(OFS_IRQ_EN, 32'h1);
		settle();
		check("irq_enabled", 32'h1, {31'h0, irq});
		wr(OFS_IRQ_EN, 32'h0);
		settle();
		check("irq_masked", 32'h0, {31'h0, irq});
		wr(OFS_CTRL, 32'h0);
		wr(OFS_IRQ_CLR, 32'h3);
		rdchk(OFS_IRQ_STAT, 32'h0, "stat_cleared");
		rdchk(OFS_IRQ_CLR, 32'h0, "clr_reads_zero");
		// Zero reload: every tick is a reload moment
		wr(OFS_A_COUNT, 32'h0);
		wr(OFS_B_COUNT, 32'h0);
		wr(OFS_CTRL, 32'h3);
		rdchk(OFS_A_COUNT, 32'hFFFF, "a_count_reload");
		rdchk(OFS_B_COUNT, 32'hFFFF, "b_count_reload");
		wr(OFS_CTRL, 32'h0);
		wr(OFS_IRQ_CLR, 32'h3);
		// Measurement: select change after start, then first edge
		wr(OFS_B_MODE, 32'h2);
		wr(OFS_CTRL, 32'h2);
		wr(OFS_IRQ_CLR, 32'h3);
		wr(OFS_B_MODE, 32'h6);
		rdchk(OFS_IRQ_STAT, 32'h2, "stat_measure_sel");
		wr(OFS_IRQ_CLR, 32'h3);
		@(posedge sys_clk) b_event_in <= 1'b1;
		settle();
		rdchk(OFS_IRQ_STAT, 32'h0, "stat_first_edge");
		conclude();
	end
endmodule
